// ===== testbench/sfrs_mem_model.sv
// Load path stand-in that answers each load after a set delay.
module sfrs_mem_model
(
	input wire mclk_i,
	input wire ld_req_i,
	input wire [31:0] ld_addr_i,
	input wire [3:0] delay_i,
	input wire [3:0] fault_i,
	output logic ld_ack_o = 0,
	output logic ld_exc_o = 0,
	output logic [2:0] ld_code_o = 0,
	output logic [31:0] ld_data_o = 0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] dly = 0;
	logic [3:0] num = 0;
	// Data flip every idle cycle so a stale word never matches.
	always @(posedge mclk_i)
	begin
		ld_ack_o <= 1'b0;
		ld_exc_o <= 1'b0;
		ld_data_o <= ~ld_data_o;
		num <= ld_req_i ? num : 4'h0;
		if (ld_req_i && !ld_ack_o && dly < delay_i)
			dly <= dly + 4'h1;
		else if (ld_req_i && !ld_ack_o)
		begin
			dly <= 4'h0;
			num <= num + 4'h1;
			ld_ack_o <= 1'b1;
			ld_exc_o <= num == fault_i;
			ld_code_o <= 3'h2;
			ld_data_o <= ~ld_addr_i;
		end
	end
endmodule // sfrs_mem_model

// ===== testbench/sfrs_restore_monitor.sv
// Checker of load order, faults and the stack pointer commit.
module sfrs_restore_monitor
(
	input wire mclk_i,
	input wire rstn_i,
	input wire issue_valid_i,
	input wire issue_ready_o,
	input wire ra_i,
	input wire [31:0] sp_i,
	input wire busy_o,
	input wire ld_req_o,
	input wire [31:0] ld_addr_o,
	input wire ld_ack_i,
	input wire ld_exc_i,
	input wire gpr_we_o,
	input wire sp_we_o,
	input wire exc_o,
	input wire [2:0] exc_code_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	// A load waits with a steady address, then each word sits 4 lower.
	ld_hold_a: assert property
		(ld_req_o && !ld_ack_i |=> ld_req_o && $stable(ld_addr_o))
		else $error("load dropped or moved");
	ld_step_a: assert property
		(ld_req_o && ld_ack_i && !ld_exc_i ##1 ld_req_o
		|-> ld_addr_o == $past(ld_addr_o) - 32'h4)
		else $error("load step wrong");
	gpr_write_a: assert property
		(ld_req_o && ld_ack_i && !ld_exc_i |=> gpr_we_o)
		else $error("no register write");
	take_load_a: assert property
		(issue_valid_i && issue_ready_o && ra_i && sp_i[1:0] == 2'h0
		|=> busy_o && ld_req_o) else $error("no first load");
	// A fault ends the sequence and must leave the pointer alone.
	fault_exc_a: assert property
		(ld_req_o && ld_ack_i && ld_exc_i
		|=> exc_o && !ld_req_o ##1 !sp_we_o [*3])
		else $error("fault not reported");
	sp_commit_a: assert property
		(sp_we_o |-> !ld_req_o && !$past(ld_req_o))
		else $error("pointer written early");
	addr_misalign_a: assert property
		(issue_valid_i && issue_ready_o && ra_i && sp_i[1:0] != 2'h0
		|=> exc_o && exc_code_o == 3'h4 && !ld_req_o)
		else $error("misalign missed");
	busy_ready_a: assert property
		(issue_valid_i && issue_ready_o |=> !issue_ready_o || exc_o)
		else $error("ready right after a take");
endmodule // sfrs_restore_monitor
bind sfrs_restore sfrs_restore_monitor i_mon
(
	.mclk_i(mclk_i), .rstn_i(rstn_i), .issue_valid_i(issue_valid_i),
	.issue_ready_o(issue_ready_o), .ra_i(ra_i), .sp_i(sp_i),
	.busy_o(busy_o), .ld_req_o(ld_req_o), .ld_addr_o(ld_addr_o),
	.ld_ack_i(ld_ack_i), .ld_exc_i(ld_exc_i), .gpr_we_o(gpr_we_o),
	.sp_we_o(sp_we_o), .exc_o(exc_o), .exc_code_o(exc_code_o)
);

// ===== testbench/stack_frame_restore_sequencer_test.sv
// Self-checking bench of the restore sequencer.
module stack_frame_restore_sequencer_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_i = 0, rstn_i = 0, avs_read_i = 0, avs_write_i = 0;
	logic issue_valid_i = 0, ra_i = 0, s0_i = 0, s1_i = 0;
	logic [2:0] xsregs_i = 0;
	logic [3:0] aregs_i = 0, dly = 0, flt = 15;
	logic [4:0] avs_address_i = 0;
	logic [7:0] framesize_i = 0;
	logic [31:0] avs_writedata_i = 0, sp_i = 0, rd;
	wire avs_waitrequest_o, irq_o, issue_ready_o, busy_o, ld_req_o;
	wire ld_ack_i, ld_exc_i, gpr_we_o, sp_we_o, exc_o;
	wire [2:0] ld_exc_code_i, exc_code_o;
	wire [4:0] gpr_wa_o;
	wire [31:0] avs_readdata_o, ld_addr_o, ld_data_i, gpr_wd_o, sp_wd_o;
	int error_cnt = 0, total_checks = 0;
	int done_cnt = 0;
	int st[16] = '{0, 1, 2, 3, 0, 1, 2, 3, 0, 1, 2, 4, 0, 1, 0, 0};
	sfrs_restore i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o), .irq_o(irq_o),
		.avs_waitrequest_o(avs_waitrequest_o), .ra_i(ra_i), .s0_i(s0_i),
		.issue_valid_i(issue_valid_i), .issue_ready_o(issue_ready_o),
		.s1_i(s1_i), .xsregs_i(xsregs_i), .aregs_i(aregs_i),
		.framesize_i(framesize_i), .sp_i(sp_i), .busy_o(busy_o),
		.ld_req_o(ld_req_o), .ld_addr_o(ld_addr_o), .ld_ack_i(ld_ack_i),
		.ld_exc_i(ld_exc_i), .ld_exc_code_i(ld_exc_code_i),
		.ld_data_i(ld_data_i), .gpr_we_o(gpr_we_o), .gpr_wa_o(gpr_wa_o),
		.gpr_wd_o(gpr_wd_o), .sp_we_o(sp_we_o), .sp_wd_o(sp_wd_o),
		.exc_o(exc_o), .exc_code_o(exc_code_o));
	sfrs_mem_model i_mem (.mclk_i(mclk_i), .ld_req_i(ld_req_o),
		.ld_addr_i(ld_addr_o), .delay_i(dly), .fault_i(flt),
		.ld_ack_o(ld_ack_i), .ld_exc_o(ld_exc_i),
		.ld_code_o(ld_exc_code_i), .ld_data_o(ld_data_i));
	// Clock of 20 ns period.
	initial
		forever #10 mclk_i = ~mclk_i;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Bus access held until waitrequest is seen low at an edge.
	task av(input logic w, input logic [4:0] a, input logic [31:0] d);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		@(posedge mclk_i);
		while (avs_waitrequest_o !== 1'b0)
			@(posedge mclk_i);
		rd = avs_readdata_o;
		avs_write_i <= 0;
		avs_read_i <= 0;
		@(posedge mclk_i);
	endtask
	// One restore; expected order and addresses are rebuilt here.
	task run(input logic [2:0] b, input logic [2:0] x, input logic [3:0] a,
		input logic [7:0] f, input logic [31:0] sp, input logic [3:0] fl);
		int q[$];
		int n;
		logic mis, bad;
		n = 0;
		q = {};
		if (b[2])
			q.push_back(31);
		if (x > 6)
			q.push_back(30);
		for (int k = (x > 6 ? 6 : x); k > 0; k--)
			q.push_back(17 + k);
		if (b[1])
			q.push_back(17);
		if (b[0])
			q.push_back(16);
		for (int k = 0; k < st[a]; k++)
			q.push_back(7 - k);
		mis = sp[1:0] != 0 && q.size() > 0;
		bad = mis || fl < q.size();
		{ra_i, s1_i, s0_i} <= b;
		xsregs_i <= x;
		aregs_i <= a;
		framesize_i <= f;
		sp_i <= sp;
		flt <= fl;
		issue_valid_i <= 1;
		@(posedge mclk_i);
		issue_valid_i <= 0;
		// A misalign answers at the take edge itself, so look first.
		#1;
		while (exc_o !== 1'b1 && sp_we_o !== 1'b1)
		begin
			@(posedge mclk_i);
			#1;
			if (gpr_we_o === 1'b1)
			begin
				chk(gpr_wa_o, q[n]);
				chk(gpr_wd_o, ~(sp + {f, 3'b0} - 4 * (n + 1)));
				n++;
			end
		end
		if (!bad)
			done_cnt++;
		chk(exc_o, bad);
		chk(n, mis ? 0 : bad ? fl : q.size());
		chk(exc_o ? exc_code_o : sp_wd_o, mis ? 4 : bad ? 2 : sp + {f, 3'b0});
		@(posedge mclk_i);
	endtask
	task t_main;
		av(0, 5'h00, 0);
		chk(rd[23], 1);
		av(0, 5'h14, 0);
		chk(rd, 0);
		dly <= 3;
		run(3'h7, 3'h7, 4'hb, 8'hff, 32'h1000, 15);
		dly <= 0;
		for (int a = 0; a < 15; a++)
			run(3'h0, 3'h0, a[3:0], 8'h01, 32'h2000, 15);
		for (int x = 0; x < 8; x++)
			run(x[2:0], x[2:0], 4'h0, 8'h00, 32'h3000, 15);
		$display("order test finished");
		av(1, 5'h08, 4);
		run(3'h4, 3'h0, 4'h0, 8'h02, 32'h40, 15);
		chk(irq_o, 0);
		run(3'h7, 3'h7, 4'h3, 8'h20, 32'h4000, 5);
		chk(irq_o, 1);
		av(0, 5'h04, 0);
		chk(rd[2], 1);
		chk(irq_o, 0);
		run(3'h7, 3'h7, 4'h3, 8'h20, 32'h4000, 15);
		run(3'h4, 3'h0, 4'h0, 8'h10, 32'h1002, 15);
		run(3'h0, 3'h0, 4'he, 8'h10, 32'h1001, 15);
		av(0, 5'h10, 0);
		chk(rd, done_cnt);
		av(1, 5'h0c, 0);
		chk(issue_ready_o, 0);
		av(1, 5'h0c, 1);
		chk(issue_ready_o, 1);
		$display("fault test finished");
	endtask
	task close_out;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Reset for two cycles, then the tests; the watchdog cuts hangs.
	initial
	begin
		repeat (2) @(posedge mclk_i);
		rstn_i <= 1;
		@(posedge mclk_i);
		t_main;
		close_out;
	end
	initial
	begin
		#400000;
		error_cnt++;
		close_out;
	end
endmodule // stack_frame_restore_sequencer_test

// ===== verilog/sfrs_regs.vh
// Constants for the stack frame restore sequencer.
`ifndef SFRS_REGS_VH
`define SFRS_REGS_VH
// Register byte offsets.
`define SFRS_OFS_CFG 5'h00
`define SFRS_OFS_STAT 5'h04
`define SFRS_OFS_MASK 5'h08
`define SFRS_OFS_CTRL 5'h0c
`define SFRS_OFS_CNT 5'h10
// Configuration word field.
`define SFRS_CFG_MULTI_BIT 23
// Status and mask bit positions.
`define SFRS_ST_DONE 0
`define SFRS_ST_ADDR 1
`define SFRS_ST_FAULT 2
`define SFRS_ST_W 3
// Control bit position and reset value.
`define SFRS_CTRL_EN 0
`define SFRS_CTRL_RST 1'h1
// Exception code for a misaligned stack pointer.
`define SFRS_EXC_ADDR 3'h4
// Word step and frame size scale.
`define SFRS_WORD 32'h0000_0004
`define SFRS_FRAME_SHIFT 3
// Load slot count and general register numbers.
`define SFRS_SLOTS 14
`define SFRS_GPR_RA 5'h1f
`define SFRS_GPR_S8 5'h1e
`define SFRS_GPR_S7 5'h17
`define SFRS_GPR_S1 5'h11
`define SFRS_GPR_S0 5'h10
`define SFRS_GPR_A3 5'h07
`endif

// ===== verilog/sfrs_restore.v
// Restore sequencer: stack loads into registers, then stack pointer update.
// Function
// - Report support through bit 23 of the configuration word.
// - Start pointer is sp plus framesize times eight; step down 4 per load.
// - With the return-address bit, first load fills register 31.
// - Load extra count from 30 (count over six), then 23 down to 18.
// - Then register 17 if second static bit, then 16 if first.
// - Decode the 4-bit argument field into a static count of 0 to 4.
// - Load registers 7, 6, 5, 4 in order until the static count.
// - Misaligned sp with any load requested raises an address error.
// - Each load may fault in translation or on the bus.
// - Variable length; after an exception the whole sequence restarts.
//
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`include "sfrs_regs.vh"
module sfrs_restore
(
	input wire mclk_i,
	input wire rstn_i,
	// Avalon-MM slave.
	input wire [4:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	output reg [31:0] avs_readdata_o,
	output wire avs_waitrequest_o,
	output wire irq_o,
	// Instruction issue.
	input wire issue_valid_i,
	output wire issue_ready_o,
	input wire ra_i,
	input wire s0_i,
	input wire s1_i,
	input wire [2:0] xsregs_i,
	input wire [3:0] aregs_i,
	input wire [7:0] framesize_i,
	input wire [31:0] sp_i,
	output wire busy_o,
	// Load path.
	output wire ld_req_o,
	output reg [31:0] ld_addr_o,
	input wire ld_ack_i,
	input wire ld_exc_i,
	input wire [2:0] ld_exc_code_i,
	input wire [31:0] ld_data_i,
	// Register file write.
	output reg gpr_we_o,
	output reg [4:0] gpr_wa_o,
	output reg [31:0] gpr_wd_o,
	// Stack pointer commit.
	output reg sp_we_o,
	output reg [31:0] sp_wd_o,
	// Exception report.
	output reg exc_o,
	output reg [2:0] exc_code_o
);

localparam ST_IDLE = 2'h0;
localparam ST_LOAD = 2'h1;
localparam ST_FIN = 2'h2;

reg [1:0] state_reg;
reg [1:0] state_next;
reg [`SFRS_SLOTS-1:0] pend_reg;
reg [31:0] ptr_reg;
reg [31:0] final_reg;
reg [2:0] astatic;
reg [`SFRS_SLOTS-1:0] pend_init;
reg [3:0] slot;
reg [`SFRS_ST_W-1:0] stat_reg;
reg [`SFRS_ST_W-1:0] mask_reg;
reg ctrl_en_reg;
reg [31:0] cnt_reg;
reg ack_reg;
reg [`SFRS_ST_W-1:0] ev;
wire take;
wire misalign;
wire acc;
wire rd_stat;
wire ld_done;
wire [31:0] top_ptr;
wire [`SFRS_SLOTS-1:0] slot_bit;

// Decode the argument field into the static register count.
always @*
begin
	case (aregs_i)
	4'h1, 4'h5, 4'h9, 4'hd: astatic = 3'h1;
	4'h2, 4'h6, 4'ha: astatic = 3'h2;
	4'h3, 4'h7: astatic = 3'h3;
	4'hb: astatic = 3'h4;
	default: astatic = 3'h0;
	endcase
end

// Build the load slots in load order; slot 0 loads first.
// The reserved argument code falls to zero statics, the safe choice.
always @*
begin
	pend_init[0] = ra_i;
	pend_init[1] = (xsregs_i > 3'h6);
	pend_init[2] = (xsregs_i > 3'h5);
	pend_init[3] = (xsregs_i > 3'h4);
	pend_init[4] = (xsregs_i > 3'h3);
	pend_init[5] = (xsregs_i > 3'h2);
	pend_init[6] = (xsregs_i > 3'h1);
	pend_init[7] = (xsregs_i > 3'h0);
	pend_init[8] = s1_i;
	pend_init[9] = s0_i;
	pend_init[10] = (astatic > 3'h0);
	pend_init[11] = (astatic > 3'h1);
	pend_init[12] = (astatic > 3'h2);
	pend_init[13] = (astatic > 3'h3);
end

// Find the first pending slot; the loop walks down so the lowest wins.
always @*
begin : pick
	integer i;
	i = 0;
	slot = 4'h0;
	for (i = `SFRS_SLOTS - 1; i >= 0; i = i - 1)
	begin
		if (pend_reg[i])
			slot = i[3:0];
	end
end

// One-hot of the chosen slot, kept at slot width so no bits are cut.
assign slot_bit = {{(`SFRS_SLOTS-1){1'b0}}, 1'b1} << slot;

// Map a load slot to the general register it fills.
function [4:0] slot_gpr;
	input [3:0] s;
	begin
		case (s)
		4'h0: slot_gpr = `SFRS_GPR_RA;
		4'h1: slot_gpr = `SFRS_GPR_S8;
		4'h8: slot_gpr = `SFRS_GPR_S1;
		4'h9: slot_gpr = `SFRS_GPR_S0;
		default:
		begin
			if (s < 4'h8)
				slot_gpr = `SFRS_GPR_S7 - {1'b0, s} + 5'h02;
			else
				slot_gpr = `SFRS_GPR_A3 - {1'b0, s} + 5'h0a;
		end
		endcase
	end
endfunction

// Top of the frame; the first load sits one word below it.
assign top_ptr = sp_i + ({24'h0, framesize_i} << `SFRS_FRAME_SHIFT);
assign take = issue_valid_i & issue_ready_o;
assign misalign = (sp_i[1:0] != 2'h0) & (pend_init != 0);
assign ld_done = (state_reg == ST_LOAD) & ld_ack_i;
assign issue_ready_o = (state_reg == ST_IDLE) & ctrl_en_reg;
assign busy_o = (state_reg != ST_IDLE);
assign ld_req_o = (state_reg == ST_LOAD);

// Sequencer state selection.
always @*
begin
	state_next = state_reg;
	case (state_reg)
	ST_IDLE:
	begin
		if (take & ~misalign)
			state_next = (pend_init != 0) ? ST_LOAD : ST_FIN;
	end
	ST_LOAD:
	begin
		if (ld_ack_i & ld_exc_i)
			state_next = ST_IDLE;
		else if (ld_ack_i && (pend_reg & ~slot_bit) == {`SFRS_SLOTS{1'b0}})
			state_next = ST_FIN;
	end
	ST_FIN: state_next = ST_IDLE;
	default: state_next = ST_IDLE;
	endcase
end

// Datapath of the sequence. A fault drops the partial work; the issue
// stage must send the instruction again, starting from the first load.
always @(posedge mclk_i or negedge rstn_i)
begin
	if (!rstn_i)
	begin
		state_reg <= ST_IDLE;
		pend_reg <= {`SFRS_SLOTS{1'b0}};
		ptr_reg <= 32'h0000_0000;
		final_reg <= 32'h0000_0000;
		ld_addr_o <= 32'h0000_0000;
		gpr_we_o <= 1'b0;
		gpr_wa_o <= 5'h00;
		gpr_wd_o <= 32'h0000_0000;
		sp_we_o <= 1'b0;
		sp_wd_o <= 32'h0000_0000;
		exc_o <= 1'b0;
		exc_code_o <= 3'h0;
	end
	else
	begin
		state_reg <= state_next;
		gpr_we_o <= 1'b0;
		sp_we_o <= 1'b0;
		exc_o <= 1'b0;
		if (take)
		begin
			// Pointer starts on the first load; the final pointer sits one word above it.
			final_reg <= top_ptr;
			ptr_reg <= top_ptr - `SFRS_WORD;
			ld_addr_o <= top_ptr - `SFRS_WORD;
			pend_reg <= pend_init;
			if (misalign)
			begin
				exc_o <= 1'b1;
				exc_code_o <= `SFRS_EXC_ADDR;
			end
		end
		else if (ld_done)
		begin
			if (ld_exc_i)
			begin
				exc_o <= 1'b1;
				exc_code_o <= ld_exc_code_i;
				pend_reg <= {`SFRS_SLOTS{1'b0}};
			end
			else
			begin
				gpr_we_o <= 1'b1;
				gpr_wa_o <= slot_gpr(slot);
				gpr_wd_o <= ld_data_i;
				pend_reg <= pend_reg & ~slot_bit;
				ptr_reg <= ptr_reg - `SFRS_WORD;
				ld_addr_o <= ptr_reg - `SFRS_WORD;
			end
		end
		else if (state_reg == ST_FIN)
		begin
			sp_we_o <= 1'b1;
			sp_wd_o <= final_reg;
		end
	end
end

// Events for the status register.
always @*
begin
	ev = {`SFRS_ST_W{1'b0}};
	ev[`SFRS_ST_DONE] = (state_reg == ST_FIN);
	ev[`SFRS_ST_ADDR] = take & misalign;
	ev[`SFRS_ST_FAULT] = ld_done & ld_exc_i;
end

// Every access waits one cycle, so read data is always registered.
assign acc = (avs_read_i | avs_write_i) & ~ack_reg;
assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
assign rd_stat = avs_read_i & ack_reg & (avs_address_i == `SFRS_OFS_STAT);
assign irq_o = |(stat_reg & mask_reg);

// Register file; a status read clears, but a new event in the same
// cycle still sets its bit so no event is lost.
always @(posedge mclk_i or negedge rstn_i)
begin
	if (!rstn_i)
	begin
		ack_reg <= 1'b0;
		avs_readdata_o <= 32'h0000_0000;
		stat_reg <= {`SFRS_ST_W{1'b0}};
		mask_reg <= {`SFRS_ST_W{1'b0}};
		ctrl_en_reg <= `SFRS_CTRL_RST;
		cnt_reg <= 32'h0000_0000;
	end
	else
	begin
		ack_reg <= acc;
		// Clear only the bits the read returned; a bit set at the
		// capture edge was not seen by software yet and must stay.
		if (rd_stat)
			stat_reg <= (stat_reg & ~avs_readdata_o[`SFRS_ST_W-1:0]) | ev;
		else
			stat_reg <= stat_reg | ev;
		if (ev[`SFRS_ST_DONE])
			cnt_reg <= cnt_reg + 32'h0000_0001;
		if (acc & avs_read_i)
		begin
			case (avs_address_i)
			`SFRS_OFS_CFG: avs_readdata_o <= 32'h1 << `SFRS_CFG_MULTI_BIT;
			`SFRS_OFS_STAT: avs_readdata_o <= {29'h0, stat_reg};
			`SFRS_OFS_MASK: avs_readdata_o <= {29'h0, mask_reg};
			`SFRS_OFS_CTRL: avs_readdata_o <= {31'h0, ctrl_en_reg};
			`SFRS_OFS_CNT: avs_readdata_o <= cnt_reg;
			default: avs_readdata_o <= 32'h0000_0000;
			endcase
		end
		if (avs_write_i & ack_reg)
		begin
			if (avs_address_i == `SFRS_OFS_MASK)
				mask_reg <= avs_writedata_i[`SFRS_ST_W-1:0];
			if (avs_address_i == `SFRS_OFS_CTRL)
				ctrl_en_reg <= avs_writedata_i[`SFRS_CTRL_EN];
		end
	end
end

endmodule // sfrs_restore
